//--- include/aur_fifo_if.sv
`timescale 1ns/100ps
interface aur_fifo_if #(parameter int WIDTH = 10);
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [WIDTH-1:0] rd_data;
  logic flush;

  modport fifo_side (
    input wr_valid, wr_data, rd_ready, flush,
    output wr_ready, rd_valid, rd_data
  );
  modport user_side (
    output wr_valid, wr_data, rd_ready, flush,
    input wr_ready, rd_valid, rd_data
  );
endinterface

//--- include/aur_pkg.sv
package aur_pkg;
  // sampling strobe runs at this multiple of the bit rate
  localparam int OVERSAMPLE = 16;
  localparam int CNT_W = 4;
  // tick counts within one oversampled bit
  localparam logic [3:0] CNT_START_CHECK = 4'h7;
  localparam logic [3:0] CNT_SAMPLE_A = 4'hd;
  localparam logic [3:0] CNT_SAMPLE_B = 4'he;
  localparam logic [3:0] CNT_BIT_END = 4'hf;
  // character layout
  localparam int DATA_BITS_SHORT = 8;
  localparam int DATA_BITS_LONG = 9;
  localparam logic [3:0] BITS_SHORT = 4'h8;
  localparam logic [3:0] BITS_LONG = 4'h9;
  localparam int FIFO_DEPTH = 2;
  // fifo word: framing error, ninth bit, low byte
  localparam int WORD_W = 10;
  localparam int POS_FRAMING_ERROR_FLAG = 9;
  localparam int POS_NINTH = 8;
  // reset values
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [8:0] RST_SHIFT = 9'h000;
  localparam logic [3:0] RST_CNT = 4'h0;

  typedef enum logic [3:0] {
    ST_HUNT = 4'h1,
    ST_START = 4'h2,
    ST_DATA = 4'h4,
    ST_STOP = 4'h8
  } aur_state_type;
endpackage

//--- tb/aur_tx_model.sv
`timescale 1ns/100ps
module aur_tx_model (
  // clock and sampling strobe
  input wire logic clk_sys,
  input wire logic baud_tick_x16,
  // serial line
  output logic serial_line
);
  // line idles at mark between frames
  initial serial_line = 1'b1;

  task automatic wait_ticks(input int n);
    repeat (n) @(posedge clk_sys iff baud_tick_x16);
  endtask

  task automatic send_char(input logic [8:0] value, input int nbits, input logic stop_level);
    serial_line <= 1'b0;
    wait_ticks(16);
    for (int i = 0; i < nbits; i++) begin
      serial_line <= value[i];
      wait_ticks(16);
    end
    serial_line <= stop_level;
    wait_ticks(16);
    serial_line <= 1'b1;
    wait_ticks(4);
  endtask

  // low pulse shorter than half a bit
  task automatic false_start();
    serial_line <= 1'b0;
    wait_ticks(4);
    serial_line <= 1'b1;
    wait_ticks(20);
  endtask
endmodule // aur_tx_model

//--- tb/test_aur_uart_rx.sv
`timescale 1ns/100ps
module test_aur_uart_rx;
  localparam int LIMIT = 40000;
  logic clk_sys;
  logic rst_n;
  logic baud_tick_x16;
  logic tick_en;
  logic [1:0] tick_div;
  logic serial_line;
  logic serial_port_enable, continuous_receive_enable, link_mode_select;
  logic nine_bit_receive_enable, address_detect_enable;
  logic receive_irq_enable, peripheral_irq_enable, global_irq_enable;
  logic data_read;
  logic [7:0] receive_data_register;
  logic received_ninth_bit, framing_error_flag, overrun_error_flag;
  logic receive_pending_flag, irq_request;
  int err_count = 0;
  int samples_checked = 0;
  int cycle_count = 0;

  aur_uart_rx DUT (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .serial_input_pin(serial_line), .baud_tick_x16(baud_tick_x16),
    .serial_port_enable(serial_port_enable),
    .continuous_receive_enable(continuous_receive_enable),
    .link_mode_select(link_mode_select),
    .nine_bit_receive_enable(nine_bit_receive_enable),
    .address_detect_enable(address_detect_enable),
    .receive_irq_enable(receive_irq_enable),
    .peripheral_irq_enable(peripheral_irq_enable),
    .global_irq_enable(global_irq_enable),
    .data_read(data_read),
    .receive_data_register(receive_data_register),
    .received_ninth_bit(received_ninth_bit),
    .framing_error_flag(framing_error_flag),
    .overrun_error_flag(overrun_error_flag),
    .receive_pending_flag(receive_pending_flag),
    .irq_request(irq_request)
  );

  aur_tx_model partner (
    .clk_sys(clk_sys), .baud_tick_x16(baud_tick_x16), .serial_line(serial_line)
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // strobe every fourth cycle keeps frames short
  initial tick_div = 2'h0;
  always @(posedge clk_sys) begin
    tick_div <= tick_div + 2'h1;
    baud_tick_x16 <= tick_en && (tick_div == 2'h3);
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycle_count = cycle_count + 1;
    if (cycle_count == LIMIT) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // order: serial_port_enable continuous_receive_enable mode nine addr rie pie gie
  task automatic set_ctrl(input logic [7:0] v);
    {serial_port_enable, continuous_receive_enable, link_mode_select,
     nine_bit_receive_enable, address_detect_enable,
     receive_irq_enable, peripheral_irq_enable, global_irq_enable} <= v;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic rx(input logic [8:0] v, input logic stop_level);
    partner.send_char(v, nine_bit_receive_enable ? 9 : 8, stop_level);
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic read_data();
    data_read <= 1'b1;
    @(posedge clk_sys);
    data_read <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  // flags are looked at before the read that pops them
  task automatic expect_head(input logic [7:0] d, input logic n, input logic f, input logic p);
    cmp_byte(receive_data_register, d);
    cmp_bit(received_ninth_bit, n);
    cmp_bit(framing_error_flag, f);
    cmp_bit(receive_pending_flag, p);
  endtask

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, err_count);
  endtask

  initial begin
    rst_n = 1'b0;
    tick_en = 1'b0;
    data_read = 1'b0;
    {serial_port_enable, continuous_receive_enable, link_mode_select,
     nine_bit_receive_enable, address_detect_enable,
     receive_irq_enable, peripheral_irq_enable, global_irq_enable} = 8'h00;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    tick_en <= 1'b1;
    set_ctrl(8'h87);
    set_ctrl(8'hc7);
    rx(9'h0a5, 1'b1);
    expect_head(8'ha5, 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      set_ctrl({5'b11000, i[2:0]});
      cmp_bit(irq_request, &i[2:0]);
    end
    set_ctrl(8'hc7);
    read_data();
    expect_head(8'h00, 1'b0, 1'b0, 1'b0);
    end_test("basic");
    rx(9'h03c, 1'b0);
    rx(9'h05a, 1'b1);
    expect_head(8'h3c, 1'b0, 1'b1, 1'b1);
    cmp_bit(irq_request, 1'b1);
    read_data();
    expect_head(8'h5a, 1'b0, 1'b0, 1'b1);
    read_data();
    rx(9'h011, 1'b0);
    rx(9'h022, 1'b0);
    read_data();
    expect_head(8'h22, 1'b0, 1'b1, 1'b1);
    set_ctrl(8'h87);
    cmp_bit(framing_error_flag, 1'b1);
    cmp_bit(receive_pending_flag, 1'b0);
    set_ctrl(8'h47);
    cmp_bit(framing_error_flag, 1'b0);
    set_ctrl(8'hc7);
    expect_head(8'h00, 1'b0, 1'b0, 1'b0);
    end_test("framing");
    rx(9'h061, 1'b1);
    rx(9'h062, 1'b1);
    rx(9'h063, 1'b1);
    cmp_bit(overrun_error_flag, 1'b1);
    expect_head(8'h61, 1'b0, 1'b0, 1'b1);
    read_data();
    expect_head(8'h62, 1'b0, 1'b0, 1'b1);
    read_data();
    rx(9'h064, 1'b1);
    expect_head(8'h00, 1'b0, 1'b0, 1'b0);
    cmp_bit(overrun_error_flag, 1'b1);
    set_ctrl(8'h87);
    set_ctrl(8'hc7);
    cmp_bit(overrun_error_flag, 1'b0);
    rx(9'h065, 1'b1);
    expect_head(8'h65, 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 2; i++) rx(9'h070, 1'b1);
    cmp_bit(overrun_error_flag, 1'b1);
    set_ctrl(8'h47);
    cmp_bit(overrun_error_flag, 1'b0);
    set_ctrl(8'hc7);
    expect_head(8'h00, 1'b0, 1'b0, 1'b0);
    end_test("overrun");
    partner.false_start();
    expect_head(8'h00, 1'b0, 1'b0, 1'b0);
    rx(9'h077, 1'b1);
    expect_head(8'h77, 1'b0, 1'b0, 1'b1);
    read_data();
    set_ctrl(8'he7);
    rx(9'h0aa, 1'b1);
    set_ctrl(8'hc7);
    expect_head(8'h00, 1'b0, 1'b0, 1'b0);
    end_test("start and mode");
    set_ctrl(8'hd7);
    rx(9'h1c3, 1'b1);
    expect_head(8'hc3, 1'b1, 1'b0, 1'b1);
    read_data();
    set_ctrl(8'hdf);
    rx(9'h055, 1'b1);
    rx(9'h1aa, 1'b1);
    expect_head(8'haa, 1'b1, 1'b0, 1'b1);
    read_data();
    expect_head(8'h00, 1'b0, 1'b0, 1'b0);
    set_ctrl(8'hd7);
    rx(9'h033, 1'b1);
    expect_head(8'h33, 1'b0, 1'b0, 1'b1);
    read_data();
    end_test("nine bit");
    print_verdict();
  end
endmodule // test_aur_uart_rx

//--- verilog/aur_fifo.sv
`timescale 1ns/100ps
module aur_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // push and pop sides
  aur_fifo_if.fifo_side port
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2) begin : g_bad_depth
    $error("aur_fifo needs a depth of at least two");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("aur_fifo needs a width of at least one");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic wr_fire;
  logic rd_fire;

  assign port.wr_ready = (count != CW'(DEPTH));
  assign port.rd_valid = (count != '0);
  assign port.rd_data = mem[rd_ptr];
  assign wr_fire = port.wr_valid & port.wr_ready;
  assign rd_fire = port.rd_valid & port.rd_ready;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (port.flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
    end else begin
      if (wr_fire) begin
        next_mem[wr_ptr] = port.wr_data;
        next_wr_ptr = bump(wr_ptr);
      end
      if (rd_fire) begin
        next_rd_ptr = bump(rd_ptr);
      end
      next_count = count + CW'(wr_fire) - CW'(rd_fire);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem <= '{default: '0};
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      mem <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  AST_FIFO_NO_OVERFILL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    count <= CW'(DEPTH))
    else $error("fifo count above depth");
endmodule // aur_fifo

//--- verilog/aur_uart_rx.sv
`timescale 1ns/100ps
module aur_uart_rx #(
  parameter int DEPTH = aur_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // serial line and sampling strobe
  input wire logic serial_input_pin,
  input wire logic baud_tick_x16,
  // control bits
  input wire logic serial_port_enable,
  input wire logic continuous_receive_enable,
  input wire logic link_mode_select,
  input wire logic nine_bit_receive_enable,
  input wire logic address_detect_enable,
  input wire logic receive_irq_enable,
  input wire logic peripheral_irq_enable,
  input wire logic global_irq_enable,
  // data register read strobe
  input wire logic data_read,
  // status and data
  output logic [7:0] receive_data_register,
  output logic received_ninth_bit,
  output logic framing_error_flag,
  output logic overrun_error_flag,
  output logic receive_pending_flag,
  output logic irq_request
);
  if (DEPTH != aur_pkg::FIFO_DEPTH) begin : g_bad_depth
    $error("aur_uart_rx overrun timing assumes a two-character fifo");
  end

  logic rst_meta_n;
  logic rst_sync_n;
  aur_pkg::aur_state_type state;
  aur_pkg::aur_state_type next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [8:0] shift;
  logic [8:0] next_shift;
  logic samp_a;
  logic next_samp_a;
  logic samp_b;
  logic next_samp_b;
  logic line_prev;
  logic next_line_prev;
  logic overrun;
  logic next_overrun;
  logic [7:0] next_data;
  logic next_ninth;
  logic next_framing_error_flag;
  logic next_pending;
  logic next_irq;
  logic rx_enabled;
  logic vote;
  logic stop_end;
  logic [7:0] char_low;
  logic char_ninth;
  logic filtered;
  logic [3:0] bits_needed;

  aur_fifo_if #(.WIDTH(aur_pkg::WORD_W)) fifo_bus ();

  aur_fifo #(
    .WIDTH(aur_pkg::WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_sync_n),
    .port(fifo_bus.fifo_side)
  );

  // release of reset is synchronised, assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  assign rx_enabled = continuous_receive_enable & ~link_mode_select & serial_port_enable;
  assign vote = (samp_a & samp_b) | (samp_a & serial_input_pin) | (samp_b & serial_input_pin);
  assign stop_end = (state == aur_pkg::ST_STOP) && baud_tick_x16 && (cnt == aur_pkg::CNT_BIT_END);
  assign bits_needed = nine_bit_receive_enable ? aur_pkg::BITS_LONG : aur_pkg::BITS_SHORT;
  assign char_low = nine_bit_receive_enable ? shift[7:0] : shift[8:1];
  assign char_ninth = nine_bit_receive_enable & shift[8];
  assign filtered = address_detect_enable & nine_bit_receive_enable & ~char_ninth;

  assign fifo_bus.wr_valid = stop_end & ~filtered & ~overrun;
  assign fifo_bus.wr_data = {~vote, char_ninth, char_low};
  assign fifo_bus.rd_ready = data_read;
  assign fifo_bus.flush = ~serial_port_enable;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_samp_a = samp_a;
    next_samp_b = samp_b;
    next_line_prev = line_prev;
    if (!rx_enabled) begin
      next_state = aur_pkg::ST_HUNT;
      next_cnt = aur_pkg::RST_CNT;
      next_bit_cnt = aur_pkg::RST_CNT;
      next_line_prev = 1'b1;
    // everything advances on the shared tick
    end else if (baud_tick_x16) begin
      next_line_prev = serial_input_pin;
      next_cnt = cnt + 4'h1;
      if (cnt == aur_pkg::CNT_SAMPLE_A) begin
        next_samp_a = serial_input_pin;
      end
      if (cnt == aur_pkg::CNT_SAMPLE_B) begin
        next_samp_b = serial_input_pin;
      end
      case (state)
        aur_pkg::ST_HUNT: begin
          next_cnt = aur_pkg::RST_CNT;
          if (line_prev && !serial_input_pin) begin
            next_state = aur_pkg::ST_START;
          end
        end
        aur_pkg::ST_START: begin
          // abort quietly if line went high
          if (cnt == aur_pkg::CNT_START_CHECK) begin
            next_cnt = aur_pkg::RST_CNT;
            next_bit_cnt = aur_pkg::RST_CNT;
            next_state = serial_input_pin ? aur_pkg::ST_HUNT : aur_pkg::ST_DATA;
          end
        end
        aur_pkg::ST_DATA: begin
          if (cnt == aur_pkg::CNT_BIT_END) begin
            next_shift = {vote, shift[8:1]};
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt + 4'h1 == bits_needed) begin
              next_state = aur_pkg::ST_STOP;
            end
          end
        end
        aur_pkg::ST_STOP: begin
          // always back to search, error or not
          if (cnt == aur_pkg::CNT_BIT_END) begin
            next_state = aur_pkg::ST_HUNT;
            next_line_prev = vote;
          end
        end
        default: begin
          next_state = aur_pkg::ST_HUNT;
        end
      endcase
    end
  end

  always_comb begin
    next_overrun = overrun;
    if (!continuous_receive_enable || !serial_port_enable) begin
      next_overrun = 1'b0;
    end else if (stop_end && !filtered && !fifo_bus.wr_ready) begin
      next_overrun = 1'b1;
    end
  end

  // head of fifo is re-registered so outputs come from flops
  always_comb begin
    next_data = aur_pkg::RST_DATA;
    next_ninth = 1'b0;
    next_framing_error_flag = 1'b0;
    // errored successors keep the flag set
    if (fifo_bus.rd_valid) begin
      next_data = fifo_bus.rd_data[7:0];
      next_ninth = fifo_bus.rd_data[aur_pkg::POS_NINTH];
      next_framing_error_flag = fifo_bus.rd_data[aur_pkg::POS_FRAMING_ERROR_FLAG];
    end
    // pending needs enable and a character
    next_pending = rx_enabled & fifo_bus.rd_valid;
    next_irq = next_pending & receive_irq_enable & peripheral_irq_enable & global_irq_enable;
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= aur_pkg::ST_HUNT;
      cnt <= aur_pkg::RST_CNT;
      bit_cnt <= aur_pkg::RST_CNT;
      shift <= aur_pkg::RST_SHIFT;
      samp_a <= 1'b1;
      samp_b <= 1'b1;
      line_prev <= 1'b1;
      overrun <= 1'b0;
      receive_data_register <= aur_pkg::RST_DATA;
      received_ninth_bit <= 1'b0;
      framing_error_flag <= 1'b0;
      overrun_error_flag <= 1'b0;
      receive_pending_flag <= 1'b0;
      irq_request <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      samp_a <= next_samp_a;
      samp_b <= next_samp_b;
      line_prev <= next_line_prev;
      overrun <= next_overrun;
      receive_data_register <= next_data;
      received_ninth_bit <= next_ninth;
      framing_error_flag <= next_framing_error_flag;
      overrun_error_flag <= next_overrun;
      receive_pending_flag <= next_pending;
      irq_request <= next_irq;
    end
  end

  sequence seq_start_check;
    state == aur_pkg::ST_START && baud_tick_x16 && cnt == aur_pkg::CNT_START_CHECK;
  endsequence

  sequence seq_port_off;
    !serial_port_enable ##1 !serial_port_enable;
  endsequence

  AST_DISABLED_HUNTS: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    !rx_enabled |=> state == aur_pkg::ST_HUNT)
    else $error("receiver left edge search while disabled");

  AST_FALSE_START: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    seq_start_check and serial_input_pin |=> state == aur_pkg::ST_HUNT && !overrun_error_flag
      || $past(overrun))
    else $error("false start not abandoned");

  AST_GOOD_START: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    seq_start_check and !serial_input_pin && rx_enabled |=> state == aur_pkg::ST_DATA && cnt == 4'h0)
    else $error("valid start did not enter data phase");

  AST_STOP_PUSH: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    stop_end && !filtered && !overrun && fifo_bus.wr_ready && serial_port_enable
      |-> fifo_bus.wr_valid && fifo_bus.wr_data[aur_pkg::POS_FRAMING_ERROR_FLAG] == !vote
      ##1 fifo_bus.rd_valid)
    else $error("completed character not stored with its stop status");

  AST_ADDR_DROP: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    stop_end && address_detect_enable && nine_bit_receive_enable && !shift[8]
      |-> !fifo_bus.wr_valid)
    else $error("address filter let a data character through");

  AST_OVERRUN_SET: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    stop_end && !filtered && !fifo_bus.wr_ready && continuous_receive_enable && serial_port_enable
      |=> overrun_error_flag ##1 overrun_error_flag || !continuous_receive_enable)
    else $error("overrun not raised on third character");

  AST_OVERRUN_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    overrun_error_flag && continuous_receive_enable && serial_port_enable
      |=> overrun_error_flag)
    else $error("overrun cleared without an enable drop");

  AST_PORT_OFF: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    seq_port_off |=> !framing_error_flag && !receive_pending_flag && !overrun_error_flag)
    else $error("port disable did not reset status");

  AST_IRQ_GATE: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    irq_request |-> receive_pending_flag && $past(receive_irq_enable)
      && $past(peripheral_irq_enable) && $past(global_irq_enable))
    else $error("interrupt raised without all enables");

  AST_PENDING_ENABLED: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    receive_pending_flag |-> $past(rx_enabled) && $past(fifo_bus.rd_valid))
    else $error("pending flag without stored character");
endmodule // aur_uart_rx
